// File: sensor_measure_params.svh
/*
 * Register offsets, field positions, reset values and check code settings
 * of the measurement control and readout block.
 * Assumes it is included by its bare name from the same folder.
 */
`ifndef SENSOR_MEASURE_PARAMS_SVH
`define SENSOR_MEASURE_PARAMS_SVH

// Register byte addresses.
`define RUN_MODE_ADDR 8'h21
`define TRIGGER_ADDR 8'h22
`define HALT_ADDR 8'h23
`define STATUS_ADDR 8'h24
`define TEMP_RES_ADDR 8'h30
`define HUM_RES_ADDR 8'h33

// Channel bit positions inside the control and status bytes.
`define TEMP_BIT 0
`define HUM_BIT 1

// Result field layout.
`define RES_DATA_W 16
`define RES_VALID_POS 16
`define RES_CRC_LSB 17
`define RES_CRC_W 7

// Reset values and CRC-7 settings.
`define RUN_MODE_RST 2'h0
`define STATUS_RST 2'h0
`define CRC_POLY 7'h09
`define CRC_INIT 7'h7f

`endif

// File: sensor_measure_pkg.sv
/*
 * Types shared by the measurement control and readout block.
 * Assumes sensor_measure_params.svh supplies the field widths.
 */
`include "sensor_measure_params.svh"

package sensor_measure_pkg;

  typedef struct packed {
    logic [`RES_CRC_W-1:0] crc;
    logic valid;
    logic [`RES_DATA_W-1:0] data;
  } result_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : sensor_measure_pkg

// File: sensor_measure_ctrl_readout.sv
/*
 * Measurement control and result readout of a humidity and temperature
 * sensor: run mode, start and halt triggers, measuring status and two
 * double buffered 24-bit results, reached through a byte register port.
 * Assumes the serial slave in front of it presents one-cycle read and
 * write strobes on clk_in, and that the sensing front end runs on clk_in,
 * answers each conversion request with a one-cycle done pulse and holds
 * its value while done is high.
 */
// Operation
// - Writing one to trigger bit 1 starts a humidity measurement.
// - Writing one to trigger bit 0 starts a temperature measurement.
// - Writing zero to a start or halt bit leaves that channel alone.
// - Writing one to halt bit 1 ends continuous humidity measurement.
// - Writing one to halt bit 0 ends continuous temperature measurement.
// - Status bit 1 reads one while humidity measures; resets to zero.
// - Status bit 0 reads one while temperature measures; resets to zero.
// - Temperature result bits 15:0 hold the little-endian value, 1/64 K.
// - Temperature result bit 16 flags valid data.
// - Temperature result bits 23:17 hold CRC-7 over value and valid.
// - Humidity result bits 15:0 hold the little-endian value, 1/512 %RH.
// - Humidity result bit 16 flags valid data.
// - Humidity result bits 23:17 hold CRC-7 over value and valid.
// - Accessing a result's first byte latches all three bytes.
`timescale 1ns/1ps
`include "sensor_measure_params.svh"

module sensor_measure_ctrl_readout (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire sensor_measure_pkg::reg_req_t reg_req_in,
  input wire logic [1:0] conv_done_in,
  input wire logic [1:0][15:0] conv_value_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [1:0] conv_req_out,
  output logic [1:0] measuring_out
);
  import sensor_measure_pkg::*;

  function automatic logic [`RES_CRC_W-1:0] crc7(
    input logic [`RES_DATA_W:0] bits
  );
    logic [`RES_CRC_W-1:0] c;
    logic fb;
    c = `CRC_INIT;
    for (int i = `RES_DATA_W; i >= 0; i--)
    begin
      fb = c[`RES_CRC_W-1] ^ bits[i];
      c = {c[`RES_CRC_W-2:0], 1'b0};
      if (fb)
      begin
        c = c ^ `CRC_POLY;
      end
    end
    return c;
  endfunction : crc7

  logic [1:0] run_mode_ff;
  logic [1:0] busy_ff;
  logic [1:0] req_ff;
  result_t live_ff [2];
  result_t snap_ff [2];
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [1:0] start_wr;
  logic [1:0] halt_wr;
  logic [7:0] nxt_rdata;

  assign start_wr = (reg_req_in.wr && reg_req_in.addr == `TRIGGER_ADDR) ?
                    reg_req_in.wdata[1:0] : 2'h0;
  assign halt_wr = (reg_req_in.wr && reg_req_in.addr == `HALT_ADDR) ?
                   reg_req_in.wdata[1:0] : 2'h0;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      run_mode_ff <= `RUN_MODE_RST;
    end
    else if (reg_req_in.wr && reg_req_in.addr == `RUN_MODE_ADDR)
    begin
      run_mode_ff <= reg_req_in.wdata[1:0];
    end
  end

  // Index 0 is temperature and index 1 humidity, matching the bit order.
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic [7:0] base;
    logic done_ok;
    assign base = (c == `HUM_BIT) ? `HUM_RES_ADDR : `TEMP_RES_ADDR;
    // A done that arrives after a halt is dropped, so a halted channel
    // keeps its last result rather than a stale late sample.
    assign done_ok = conv_done_in[c] && busy_ff[c];

    // Measuring status; a start in the same cycle wins.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        busy_ff[c] <= 1'b0;
      end
      else if (start_wr[c])
      begin
        busy_ff[c] <= 1'b1;
      end
      else if (halt_wr[c] && run_mode_ff[c])
      begin
        busy_ff[c] <= 1'b0;
      end
      else if (done_ok && !run_mode_ff[c])
      begin
        busy_ff[c] <= 1'b0;
      end
    end

    // Continuous mode rearms the front end after every sample, except one that arrives with a halt write in the same cycle.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        req_ff[c] <= 1'b0;
      end
      else
      begin
        req_ff[c] <= start_wr[c] ||
                     (done_ok && run_mode_ff[c] && !halt_wr[c]);
      end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        live_ff[c] <= '0;
      end
      else if (done_ok)
      begin
        live_ff[c].data <= conv_value_in[c];
        live_ff[c].valid <= 1'b1;
        live_ff[c].crc <= crc7({1'b1, conv_value_in[c]});
      end
    end

    // Any access to the base latches, read or write, so a host that
    // pokes the base before a burst still gets a coherent snapshot.
    // Snapshot on first byte access.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        snap_ff[c] <= '0;
      end
      else if ((reg_req_in.rd || reg_req_in.wr) && reg_req_in.addr == base)
      begin
        snap_ff[c] <= live_ff[c];
      end
    end
  end

  // Byte 0 comes from the live copy, since it is latched in this cycle.
  always_comb
  begin
    nxt_rdata = 8'h00;
    case (reg_req_in.addr)
      `RUN_MODE_ADDR: nxt_rdata = {6'h00, run_mode_ff};
      `STATUS_ADDR: nxt_rdata = {6'h00, busy_ff};
      `TEMP_RES_ADDR: nxt_rdata = live_ff[`TEMP_BIT][7:0];
      `TEMP_RES_ADDR + 8'h01: nxt_rdata = snap_ff[`TEMP_BIT][15:8];
      `TEMP_RES_ADDR + 8'h02: nxt_rdata = snap_ff[`TEMP_BIT][23:16];
      `HUM_RES_ADDR: nxt_rdata = live_ff[`HUM_BIT][7:0];
      `HUM_RES_ADDR + 8'h01: nxt_rdata = snap_ff[`HUM_BIT][15:8];
      `HUM_RES_ADDR + 8'h02: nxt_rdata = snap_ff[`HUM_BIT][23:16];
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data holds between reads, so a slow serial slave can shift it
  // out later; the cost is one flop stage of read latency.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_req_in.rd;
      if (reg_req_in.rd)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;
  assign conv_req_out = req_ff;
  assign measuring_out = busy_ff;

  // The checks below watch only what this block drives or decodes, so they
  // stay valid whatever order the host uses on the register port.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  hum_start_a: assert property (
    start_wr[1] |=> busy_ff[1] && req_ff[1])
    else $error("humidity start not taken");
  temp_start_a: assert property (
    start_wr[0] |=> busy_ff[0] && req_ff[0])
    else $error("temperature start not taken");
  zero_write_a: assert property (
    reg_req_in.wr && !start_wr[0] && !halt_wr[0] && !conv_done_in[0]
    |=> $stable(busy_ff[0]))
    else $error("zero write disturbed channel");
  hum_halt_a: assert property (
    halt_wr[1] && run_mode_ff[1] && !start_wr[1]
    |=> !busy_ff[1] && !req_ff[1])
    else $error("humidity halt ignored");
  single_halt_a: assert property (
    halt_wr[1] && !run_mode_ff[1] && busy_ff[1] && !conv_done_in[1]
    |=> busy_ff[1])
    else $error("halt ended a single shot");
  temp_halt_a: assert property (
    halt_wr[0] && run_mode_ff[0] && !start_wr[0]
    |=> !busy_ff[0] && !req_ff[0])
    else $error("temperature halt ignored");
  late_done_a: assert property (
    conv_done_in[0] && !busy_ff[0] |=> $stable(live_ff[0]))
    else $error("late sample overwrote result");

  status_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `STATUS_ADDR
    |=> reg_rvalid_out && reg_rdata_out == {6'h00, $past(busy_ff)})
    else $error("status byte wrong");
  single_end_a: assert property (
    conv_done_in[0] && busy_ff[0] && !run_mode_ff[0] && !start_wr[0]
    |=> !busy_ff[0])
    else $error("single shot did not end");
  cont_rearm_a: assert property (
    conv_done_in[1] && busy_ff[1] && run_mode_ff[1] && !halt_wr[1]
    |=> busy_ff[1] && req_ff[1])
    else $error("continuous run not rearmed");

  capture_a: assert property (
    conv_done_in[0] && busy_ff[0]
    |=> live_ff[0].valid && live_ff[0].data == $past(conv_value_in[0]))
    else $error("temperature result not captured");
  temp_crc_a: assert property (
    conv_done_in[0] && busy_ff[0]
    |=> live_ff[0].crc == crc7({1'b1, $past(conv_value_in[0])}))
    else $error("temperature crc mismatch");
  hum_capture_a: assert property (
    conv_done_in[1] && busy_ff[1]
    |=> live_ff[1].valid && live_ff[1].data == $past(conv_value_in[1]))
    else $error("humidity result not captured");
  crc_field_a: assert property (
    conv_done_in[1] && busy_ff[1]
    |=> live_ff[1].crc == crc7({1'b1, $past(conv_value_in[1])}))
    else $error("humidity crc mismatch");
  byte0_live_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `TEMP_RES_ADDR
    |=> reg_rdata_out == $past(live_ff[0][7:0]))
    else $error("first result byte not live");
  snapshot_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `TEMP_RES_ADDR
    ##1 reg_req_in.rd && reg_req_in.addr == `TEMP_RES_ADDR + 8'h01
    |=> reg_rdata_out == $past(live_ff[0][15:8], 2))
    else $error("snapshot byte not coherent");

  // Scenarios the bench is expected to reach.
  cont_cov_c: cover property (run_mode_ff[1] && conv_done_in[1]
    && busy_ff[1] ##1 req_ff[1]);
  single_cov_c: cover property (start_wr[0] ##[1:50] !busy_ff[0]);
  burst_cov_c: cover property (reg_req_in.rd
    && reg_req_in.addr == `HUM_RES_ADDR ##1 reg_req_in.rd
    && reg_req_in.addr == `HUM_RES_ADDR + 8'h01);
  halt_cov_c: cover property (halt_wr[0] && run_mode_ff[0] && busy_ff[0]);
  late_cov_c: cover property (conv_done_in[0] && !busy_ff[0]);

endmodule : sensor_measure_ctrl_readout

// File: sense_front_model.sv
/* Behavioural sensing front end facing the readout block.
   Assumes one-cycle conversion requests on the block clock. */
`timescale 1ns/1ps
module sense_front_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] req_in,
  input wire logic [3:0] dly_in,
  input wire logic [1:0][15:0] val_in,
  output logic [1:0] done_out,
  output logic [1:0][15:0] value_out
);
  logic [1:0][4:0] cnt_ff;
  // Outside a done pulse the value toggles, so stale data never matches.
  always @(posedge clk_in or negedge nrst_in)
    for (int c = 0; c < 2; c++)
    begin
      if (!nrst_in)
      begin
        cnt_ff[c] <= 5'h00;
        done_out[c] <= 1'b0;
        value_out[c] <= 16'h0000;
      end
      else
      begin
        done_out[c] <= cnt_ff[c] == 5'h01;
        value_out[c] <= (cnt_ff[c] == 5'h01) ? val_in[c] : ~value_out[c];
        if (req_in[c])
          cnt_ff[c] <= {1'b0, dly_in} + 5'h01;
        else if (cnt_ff[c] != 5'h00)
          cnt_ff[c] <= cnt_ff[c] - 5'h01;
      end
    end
endmodule : sense_front_model

// File: tb_sensor_measure_ctrl_readout.sv
/* Self-checking bench for the measurement control and readout block.
   Assumes the behavioural front end model answers conversion requests. */
`timescale 1ns/1ps
`include "sensor_measure_params.svh"
module tb_sensor_measure_ctrl_readout;
  import sensor_measure_pkg::*;
  logic clk_in, nrst_in, rvalid;
  reg_req_t req;
  logic [1:0] done, creq, meas;
  logic [1:0][15:0] value, val;
  logic [7:0] rdata;
  logic [3:0] dly;
  int bad_count, cmp_count;
  // Rows are {write, address, data or expected read byte}.
  logic [16:0] rows [8] = '{{1'b1, 8'h21, 8'h03}, {1'b0, 8'h21, 8'h03},
    {1'b1, 8'h21, 8'h00}, {1'b0, 8'h21, 8'h00}, {1'b0, 8'h22, 8'h00},
    {1'b0, 8'h23, 8'h00}, {1'b0, 8'h24, 8'h00}, {1'b0, 8'h50, 8'h00}};
  sensor_measure_ctrl_readout dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .reg_req_in(req), .conv_done_in(done), .conv_value_in(value),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .conv_req_out(creq), .measuring_out(meas));
  sense_front_model fe (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(creq), .dly_in(dly), .val_in(val), .done_out(done),
    .value_out(value));
  task automatic results();
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) #1 req = '{a, 1'b1, 1'b0, d};
    @(posedge clk_in) #1 req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in) #1 req = '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk_in) #1 req = '0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask : rd
  task automatic wt(input int c);
    int n = 0;
    while (meas[c] === 1'b1 && n < 40)
      @(posedge clk_in) #1 n++;
    if (meas[c] !== 1'b0)
    begin
      bad_count++;
      results();
    end
  endtask : wt
  function automatic logic [6:0] crc7(input logic [16:0] b);
    logic [6:0] r;
    r = `CRC_INIT;
    for (int i = 16; i >= 0; i--)
      r = {r[5:0], 1'b0} ^ ((b[i] ^ r[6]) ? `CRC_POLY : 7'h00);
    return r;
  endfunction : crc7
  task automatic res(input int c, input logic [15:0] v);
    logic [7:0] base;
    base = c ? `HUM_RES_ADDR : `TEMP_RES_ADDR;
    // Three reads on consecutive edges, as a burst from the serial slave.
    @(posedge clk_in) #1 req = '{base, 1'b0, 1'b1, 8'h00};
    @(posedge clk_in) #1 req.addr = base + 8'h01;
    chk(rdata, v[7:0]);
    @(posedge clk_in) #1 req.addr = base + 8'h02;
    chk(rdata, v[15:8]);
    @(posedge clk_in) #1 req.rd = 1'b0;
    chk(rdata, {crc7({1'b1, v}), 1'b1});
    chk({7'h00, rvalid}, 8'h01);
  endtask : res
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    nrst_in = 1'b0;
    req = '0;
    val = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    chk({6'h00, meas}, 8'h00);
    foreach (rows[i])
      if (rows[i][16])
        wr(rows[i][15:8], rows[i][7:0]);
      else
        rd(rows[i][15:8], rows[i][7:0]);
    for (int c = 0; c < 2; c++)
    begin
      val[c] = 16'h9ac5 + 16'(c);
      dly = c ? 4'hc : 4'h1;
      wr(`TRIGGER_ADDR, 8'h00);
      chk({6'h00, meas}, 8'h00);
      wr(`TRIGGER_ADDR, 8'(1 << c));
      chk({6'h00, meas}, 8'(1 << c));
      rd(`STATUS_ADDR, 8'(1 << c));
      wt(c);
      res(c, val[c]);
    end
    rd(`TEMP_RES_ADDR, 8'hc5);
    val[0] = 16'h5e17;
    wr(`TRIGGER_ADDR, 8'h01);
    wt(0);
    rd(`TEMP_RES_ADDR + 8'h01, 8'h9a);
    res(0, val[0]);
    wr(`RUN_MODE_ADDR, 8'h03);
    wr(`TRIGGER_ADDR, 8'h03);
    repeat (30) @(posedge clk_in);
    #1 chk({6'h00, meas}, 8'h03);
    wr(`HALT_ADDR, 8'h00);
    chk({6'h00, meas}, 8'h03);
    wr(`HALT_ADDR, 8'h01);
    chk({6'h00, meas}, 8'h02);
    wr(`HALT_ADDR, 8'h02);
    chk({6'h00, meas}, 8'h00);
    repeat (16) @(posedge clk_in);
    #1 chk({6'h00, meas}, 8'h00);
    wr(`TRIGGER_ADDR, 8'h01);
    @(posedge clk_in) #1 nrst_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    chk({6'h00, meas}, 8'h00);
    rd(`RUN_MODE_ADDR, 8'h00);
    rd(`TEMP_RES_ADDR + 8'h02, 8'h00);
    wr(`TRIGGER_ADDR, 8'h02);
    wr(`HALT_ADDR, 8'h02);
    chk({6'h00, meas}, 8'h02);
    wt(1);
    res(1, val[1]);
    results();
  end
endmodule : tb_sensor_measure_ctrl_readout
